// [hw/mcr_pkg.sv]
// Machine-check reporting: shared register map, field layout and types
// Assumes a 125 MHz system clock and a 12-bit AXI4-Lite byte address
package mcr_pkg;
    localparam int NB = 4;
    localparam logic [3:0] NB_IDX = 4'h4;
    localparam logic [7:0] CAP_COUNT = 8'h04;
    localparam logic [11:0] A_GCAP = 12'h000;
    localparam logic [11:0] A_GSTAT = 12'h004;
    localparam logic [11:0] A_FCTL = 12'h008;
    localparam logic [11:0] A_LTYPE = 12'h010;
    localparam logic [11:0] A_LADDR = 12'h014;
    localparam logic [3:0] A_BANK_PAGE = 4'h4;
    localparam logic [3:0] B_CTL = 4'h0;
    localparam logic [3:0] B_STAT = 4'h4;
    localparam logic [3:0] B_ADDR = 4'h8;
    localparam int ST_VALID = 31;
    localparam int ST_OVER = 30;
    localparam int ST_UNCORR = 29;
    localparam int ST_EN = 28;
    localparam int ST_CORRUPT = 25;
    localparam int G_RESTART = 0;
    localparam int G_ERRPTR = 1;
    localparam int G_INPROG = 2;
    localparam int FC_CHK_EN = 0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] EXC_VECTOR = 8'h12;
    localparam int CLK_NS = 8;
    localparam int AGG_NS = 64;
    localparam logic [3:0] AGG_CYC = 4'(AGG_NS / CLK_NS);
    localparam logic [1:0] SEV_NONE = 2'h0;
    localparam logic [1:0] SEV_RECOV = 2'h1;
    localparam logic [1:0] SEV_FATAL = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] STRB_ALL = 4'hF;

    typedef struct packed {
        logic hit;
        logic uncorr;
        logic corrupt;
        logic restart;
        logic errptr;
        logic [15:0] code;
        logic [31:0] addr;
    } mcr_err_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_COLLECT = 2'b01,
        S_SHUT = 2'b10
    } mcr_state_t;
endpackage

// [hw/mcr_bank.sv]
// One error-reporting bank: status word and error address
// Assumes error reports arrive as one-cycle pulses on the system clock
`timescale 1ns/1ps
module mcr_bank (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input mcr_pkg::mcr_err_t i_err,
    input wire logic i_en,
    input wire logic i_wr_stat,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_stat_q,
    output logic [31:0] o_addr_q
);
    import mcr_pkg::*;

    logic [31:0] base;
    logic take;

    // Software write first, then the new error on top: a report never loses to a clear
    always_comb begin
        base = i_wr_stat ? i_wdata : o_stat_q;
        take = i_err.hit && (!base[ST_VALID] || (i_err.uncorr && !base[ST_UNCORR]));
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_stat_q <= RST_WORD;
        end else begin
            o_stat_q <= base;
            if (i_err.hit && base[ST_VALID]) begin
                o_stat_q[ST_OVER] <= 1'b1;
            end
            if (take) begin
                o_stat_q[ST_VALID] <= 1'b1;
                o_stat_q[ST_UNCORR] <= i_err.uncorr;
                o_stat_q[ST_CORRUPT] <= i_err.corrupt;
                o_stat_q[ST_EN] <= i_en;
                o_stat_q[15:0] <= i_err.code;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_addr_q <= RST_WORD;
        end else if (take) begin
            o_addr_q <= i_err.addr;
        end
    end

    a_unrecov_flags: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_err.hit && i_err.uncorr && i_err.corrupt && i_en && !base[ST_VALID]) |=>
        (o_stat_q[ST_VALID] && o_stat_q[ST_UNCORR] && o_stat_q[ST_CORRUPT] && o_stat_q[ST_EN]))
        else $error("unrecoverable error flags not all set");

    a_uncorr_follows: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_err.hit && !base[ST_VALID]) |=> (o_stat_q[ST_UNCORR] == $past(i_err.uncorr)) && o_stat_q[ST_VALID])
        else $error("uncorrected flag does not match report");
endmodule

// [hw/mcr_unit.sv]
// Machine-check reporting unit: banks, global status, capability, legacy registers
// Assumes error reports from same-clock logic and an AXI4-Lite master for software
//
// Contract
// - Close errors merge into one exception event
// - Unrecoverable sets valid, uncorrected, corrupt, enabled
// - Global pointers follow most severe merged error
// - Exception uses vector 18
// - Capability count field gives bank count
// - Bank zero first register at 400H
// - Bank valid flag marks meaningful contents
// - Corrupt or overflow set when unrecoverable
// - Uncorrected flag shows automatic correction status
// - Restart pointer valid only when resumable
// - Error pointer valid when instruction related
// - In-progress flag set on every exception
// - Exception during in-progress forces shutdown
// - Condition signalled to all sharing processors
// - Exceptions and legacy reads need enable bit
// - Legacy registers need not stay meaningful
`timescale 1ns/1ps
module mcr_unit (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input mcr_pkg::mcr_err_t [mcr_pkg::NB-1:0] i_err,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [11:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [11:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_exc,
    output logic [7:0] o_exc_vector,
    output logic o_check_signal,
    output logic o_shutdown
);
    import mcr_pkg::*;

    logic aw_rdy_q, w_rdy_q, b_vld_q, ar_rdy_q, r_vld_q;
    logic [1:0] b_resp_q, r_resp_q;
    logic [31:0] r_data_q, wdata_q;
    logic [11:0] waddr_q;
    logic [3:0] wstrb_q;
    logic chk_en_q, restart_q, errptr_q, inprog_q;
    logic [NB-1:0] bank_en_q;
    logic [31:0] ltype_q, laddr_q;
    logic exc_q, bcast_q, shut_q;
    logic [7:0] vec_q;
    mcr_state_t state_q;
    logic [3:0] cnt_q;
    logic [1:0] agg_sev_q;
    logic agg_restart_q, agg_errptr_q;
    logic [15:0] agg_code_q;
    logic [31:0] agg_addr_q;
    logic [31:0] stat_w [NB];
    logic [31:0] addr_w [NB];
    logic [NB-1:0] wr_stat;
    logic wr_go, wr_ok, rd_map;
    logic [31:0] rd_word;
    logic [1:0] cur_sev, fin_sev;
    logic cur_restart, cur_errptr, fin_restart, fin_errptr;
    logic [15:0] cur_code, fin_code;
    logic [31:0] cur_addr, fin_addr;
    logic fire, raise;

    function automatic logic glob_hit(input logic [11:0] a);
        glob_hit = (a == A_GCAP) || (a == A_GSTAT) || (a == A_FCTL) || (a == A_LTYPE) || (a == A_LADDR);
    endfunction

    // Bank registers sit from 400H upward, one 16-byte group per bank
    function automatic logic bank_hit(input logic [11:0] a);
        bank_hit = (a[11:8] == A_BANK_PAGE) && (a[7:4] < NB_IDX) &&
            ((a[3:0] == B_CTL) || (a[3:0] == B_STAT) || (a[3:0] == B_ADDR));
    endfunction

    assign o_awready = aw_rdy_q;
    assign o_wready = w_rdy_q;
    assign o_bvalid = b_vld_q;
    assign o_bresp = b_resp_q;
    assign o_arready = ar_rdy_q;
    assign o_rvalid = r_vld_q;
    assign o_rdata = r_data_q;
    assign o_rresp = r_resp_q;
    assign o_exc = exc_q;
    assign o_exc_vector = vec_q;
    assign o_check_signal = bcast_q;
    assign o_shutdown = shut_q;

    genvar gb;
    generate
        for (gb = 0; gb < NB; gb++) begin : g_bank
            assign wr_stat[gb] = wr_go && wr_ok && bank_hit(waddr_q) &&
                (waddr_q[7:4] == 4'(gb)) && (waddr_q[3:0] == B_STAT);
            mcr_bank u_bank (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_err(i_err[gb]),
                .i_en(bank_en_q[gb]),
                .i_wr_stat(wr_stat[gb]),
                .i_wdata(wdata_q),
                .o_stat_q(stat_w[gb]),
                .o_addr_q(addr_w[gb])
            );
        end
    endgenerate

    // Most severe enabled uncorrected report this cycle; corrected ones raise nothing
    always_comb begin
        logic [1:0] s;
        s = SEV_NONE;
        cur_sev = SEV_NONE;
        cur_restart = 1'b0;
        cur_errptr = 1'b0;
        cur_code = 16'h0000;
        cur_addr = RST_WORD;
        for (int b = 0; b < NB; b++) begin
            s = (i_err[b].hit && i_err[b].uncorr && bank_en_q[b]) ?
                (i_err[b].corrupt ? SEV_FATAL : SEV_RECOV) : SEV_NONE;
            if (s > cur_sev) begin
                cur_sev = s;
                cur_restart = i_err[b].restart;
                cur_errptr = i_err[b].errptr;
                cur_code = i_err[b].code;
                cur_addr = i_err[b].addr;
            end
        end
    end

    // Latecomers in the last window cycle still count toward the event
    always_comb begin
        if (cur_sev > agg_sev_q) begin
            fin_sev = cur_sev;
            fin_restart = cur_restart;
            fin_errptr = cur_errptr;
            fin_code = cur_code;
            fin_addr = cur_addr;
        end else begin
            fin_sev = agg_sev_q;
            fin_restart = agg_restart_q;
            fin_errptr = agg_errptr_q;
            fin_code = agg_code_q;
            fin_addr = agg_addr_q;
        end
    end

    assign fire = (state_q == S_COLLECT) && (cnt_q == 4'h0);
    assign raise = fire && chk_en_q && !inprog_q;

    // Errors inside one window are merged and reported once
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (cur_sev != SEV_NONE) begin
                        state_q <= S_COLLECT;
                        cnt_q <= AGG_CYC - 4'h1;
                    end
                end
                S_COLLECT: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (fire) begin
                        state_q <= (chk_en_q && inprog_q) ? S_SHUT : S_IDLE;
                    end
                end
                S_SHUT: begin
                    state_q <= S_SHUT;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            agg_sev_q <= SEV_NONE;
            agg_restart_q <= 1'b0;
            agg_errptr_q <= 1'b0;
            agg_code_q <= 16'h0000;
            agg_addr_q <= RST_WORD;
        end else if (fire || state_q == S_IDLE) begin
            agg_sev_q <= cur_sev;
            agg_restart_q <= cur_restart;
            agg_errptr_q <= cur_errptr;
            agg_code_q <= cur_code;
            agg_addr_q <= cur_addr;
        end else begin
            agg_sev_q <= fin_sev;
            agg_restart_q <= fin_restart;
            agg_errptr_q <= fin_errptr;
            agg_code_q <= fin_code;
            agg_addr_q <= fin_addr;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            exc_q <= 1'b0;
            bcast_q <= 1'b0;
            vec_q <= 8'h00;
            shut_q <= 1'b0;
        end else begin
            exc_q <= raise;
            bcast_q <= raise;
            vec_q <= raise ? EXC_VECTOR : 8'h00;
            shut_q <= shut_q || (fire && chk_en_q && inprog_q);
        end
    end

    // Hardware set wins over a software write in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            restart_q <= 1'b0;
            errptr_q <= 1'b0;
            inprog_q <= 1'b0;
        end else if (raise) begin
            inprog_q <= 1'b1;
            restart_q <= (fin_sev == SEV_RECOV) && fin_restart;
            errptr_q <= fin_errptr;
        end else if (wr_go && wr_ok && waddr_q == A_GSTAT) begin
            inprog_q <= wdata_q[G_INPROG];
            restart_q <= wdata_q[G_RESTART];
            errptr_q <= wdata_q[G_ERRPTR];
        end
    end

    // Legacy capture is best effort only; software should prefer the banks
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ltype_q <= RST_WORD;
            laddr_q <= RST_WORD;
        end else if (raise) begin
            ltype_q <= {16'h0000, fin_code};
            laddr_q <= fin_addr;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            chk_en_q <= 1'b0;
            bank_en_q <= '0;
        end else if (wr_go && wr_ok) begin
            if (waddr_q == A_FCTL) begin
                chk_en_q <= wdata_q[FC_CHK_EN];
            end
            for (int b = 0; b < NB; b++) begin
                if (bank_hit(waddr_q) && waddr_q[7:4] == 4'(b) && waddr_q[3:0] == B_CTL) begin
                    bank_en_q[b] <= wdata_q[0];
                end
            end
        end
    end

    // Partial-strobe writes are refused whole rather than merged
    assign wr_go = !aw_rdy_q && !w_rdy_q && !b_vld_q;
    assign wr_ok = (glob_hit(waddr_q) || bank_hit(waddr_q)) && (wstrb_q == STRB_ALL);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
            b_vld_q <= 1'b0;
            b_resp_q <= RESP_OKAY;
            waddr_q <= 12'h000;
            wdata_q <= RST_WORD;
            wstrb_q <= 4'h0;
        end else begin
            if (i_awvalid && aw_rdy_q) begin
                aw_rdy_q <= 1'b0;
                waddr_q <= i_awaddr;
            end
            if (i_wvalid && w_rdy_q) begin
                w_rdy_q <= 1'b0;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (wr_go) begin
                b_vld_q <= 1'b1;
                b_resp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (b_vld_q && i_bready) begin
                b_vld_q <= 1'b0;
                aw_rdy_q <= 1'b1;
                w_rdy_q <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_map = glob_hit(i_araddr) || bank_hit(i_araddr);
        rd_word = RST_WORD;
        case (i_araddr)
            A_GCAP: rd_word[7:0] = CAP_COUNT;
            A_GSTAT: begin
                rd_word[G_RESTART] = restart_q;
                rd_word[G_ERRPTR] = errptr_q;
                rd_word[G_INPROG] = inprog_q;
            end
            A_FCTL: rd_word[FC_CHK_EN] = chk_en_q;
            A_LTYPE: rd_word = chk_en_q ? ltype_q : RST_WORD;
            A_LADDR: rd_word = chk_en_q ? laddr_q : RST_WORD;
            default: begin
                for (int b = 0; b < NB; b++) begin
                    if (bank_hit(i_araddr) && i_araddr[7:4] == 4'(b)) begin
                        if (i_araddr[3:0] == B_CTL) begin
                            rd_word[0] = bank_en_q[b];
                        end else if (i_araddr[3:0] == B_STAT) begin
                            rd_word = stat_w[b];
                        end else begin
                            rd_word = addr_w[b];
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ar_rdy_q <= 1'b1;
            r_vld_q <= 1'b0;
            r_data_q <= RST_WORD;
            r_resp_q <= RESP_OKAY;
        end else if (i_arvalid && ar_rdy_q) begin
            ar_rdy_q <= 1'b0;
            r_vld_q <= 1'b1;
            r_data_q <= rd_word;
            r_resp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (r_vld_q && i_rready) begin
            r_vld_q <= 1'b0;
            ar_rdy_q <= 1'b1;
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    a_exc_vector: assert property (exc_q |-> vec_q == EXC_VECTOR && bcast_q)
        else $error("exception without vector 18");
    a_exc_enable: assert property (exc_q |-> $past(chk_en_q) && inprog_q)
        else $error("exception while disabled or without in-progress flag");
    a_recursion_shut: assert property ((fire && chk_en_q && inprog_q) |=> shut_q && !exc_q)
        else $error("recursive check did not shut down");
    a_restart_fatal: assert property ((raise && fin_sev == SEV_FATAL) |=> !restart_q && inprog_q)
        else $error("restart pointer valid on fatal error");
    a_agg_window: assert property ((state_q == S_IDLE && cur_sev != SEV_NONE) |-> ##8 fire)
        else $error("aggregation window length wrong");
    a_single_event: assert property (exc_q |=> !exc_q [*2])
        else $error("merged errors raised more than one exception");
    a_legacy_hide: assert property ((i_arvalid && ar_rdy_q && i_araddr == A_LTYPE && !chk_en_q)
        |=> r_vld_q && r_data_q == RST_WORD)
        else $error("legacy type readable while disabled");
    a_cap_count: assert property ((i_arvalid && ar_rdy_q && i_araddr == A_GCAP)
        |=> r_vld_q && r_data_q[7:0] == CAP_COUNT && r_resp_q == RESP_OKAY)
        else $error("capability count wrong");
endmodule

// [dv/machine_check_reporting_test.sv]
// Self-checking bench for the machine-check reporting unit
// Assumes mcr_pkg and mcr_unit compiled first; drives AXI4-Lite and error reports itself
`timescale 1ns/1ps
module machine_check_reporting_test;
    import mcr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    mcr_err_t [NB-1:0] err = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = STRB_ALL;
    logic awready, wready, bvalid, arready, rvalid, exc, chk, shut;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] vector, vec_seen;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int exc_cnt = 0, sig_cnt = 0, exc_at = 0, last_t0 = 0, t0 = 0;

    mcr_unit mcr_unit_inst (.i_clk_sys(clk_sys), .i_rst(rst), .i_err(err),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .o_exc(exc), .o_exc_vector(vector), .o_check_signal(chk), .o_shutdown(shut));

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    // Pulses are sampled mid-cycle so they never race the launching edge
    always @(negedge clk_sys) begin
        if (exc === 1'b1) begin
            exc_cnt++;
            exc_at = cyc;
            vec_seen = vector;
        end
        if (chk === 1'b1) sig_cnt++;
    end

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timed_out(input string what);
        failures++;
        $display("[FAIL] %s expected handshake seen timeout", what);
        print_verdict();
    endtask

    // Handshake values are read right after the edge, before any flop update lands
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er, input string what);
        logic aw_open, w_open;
        int n;
        aw_open = 1'b1;
        w_open = 1'b1;
        @(posedge clk_sys);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (aw_open && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_open = 1'b0;
            end
            if (w_open && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_open = 1'b0;
            end
            if (bvalid === 1'b1) break;
        end
        if (n == 50) timed_out(what);
        bready <= 1'b0;
        check(what, {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        @(posedge clk_sys);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                break;
            end
        end
        if (n == 50) timed_out(what);
        rready <= 1'b0;
        check(what, exp, d);
        check(what, {30'h0, er}, {30'h0, r});
    endtask

    function automatic mcr_err_t mk(logic u, logic c, logic r, logic e, logic [15:0] code, logic [31:0] addr);
        return '{hit: 1'b1, uncorr: u, corrupt: c, restart: r, errptr: e, code: code, addr: addr};
    endfunction

    function automatic logic [11:0] bank_a(int b, logic [3:0] off);
        return 12'h400 + 12'(b * 16) + {8'h00, off};
    endfunction

    // One-cycle report; last_t0 is the cycle count of the edge that takes it
    task automatic err_pulse(input int b, input mcr_err_t e);
        @(posedge clk_sys);
        err[b] <= e;
        @(posedge clk_sys);
        err[b].hit <= 1'b0;
        #1;
        last_t0 = cyc;
    endtask

    task automatic settle();
        exc_cnt = 0;
        sig_cnt = 0;
        repeat (20) @(posedge clk_sys);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd_check(A_GCAP, {24'h0, CAP_COUNT}, RESP_OKAY, "bank count");
        rd_check(A_GSTAT, 32'h0000_0000, RESP_OKAY, "global status reset");
        rd_check(12'h0FC, 32'h0000_0000, RESP_SLVERR, "unmapped read");
        axi_write(A_GCAP, 32'hFFFF_FFFF, RESP_OKAY, "read-only write");
        rd_check(A_GCAP, {24'h0, CAP_COUNT}, RESP_OKAY, "bank count kept");
        $display("test registers done");

        axi_write(A_FCTL, 32'h0000_0001, RESP_OKAY, "enable bit");
        // A partial strobe must be refused whole, leaving the enable set
        wstrb <= 4'h3;
        axi_write(A_FCTL, 32'h0000_0000, RESP_SLVERR, "partial strobe");
        wstrb <= STRB_ALL;
        rd_check(A_FCTL, 32'h0000_0001, RESP_OKAY, "enable kept");
        for (int b = 0; b < NB; b++) axi_write(bank_a(b, B_CTL), 32'h0000_0001, RESP_OKAY, "bank enable");
        rd_check(12'h400, 32'h0000_0001, RESP_OKAY, "bank zero control");
        rd_check(bank_a(1, B_STAT), 32'h0000_0000, RESP_OKAY, "empty bank status");
        settle();
        err_pulse(1, mk(1'b0, 1'b0, 1'b0, 1'b0, 16'h0011, 32'h0000_0100));
        err_pulse(1, mk(1'b0, 1'b0, 1'b0, 1'b0, 16'h0012, 32'h0000_0200));
        repeat (20) @(posedge clk_sys);
        check("corrected no exception", 32'h0, 32'(exc_cnt));
        rd_check(bank_a(1, B_STAT), 32'hD000_0011, RESP_OKAY, "corrected overflow");
        $display("test corrected done");

        settle();
        err_pulse(0, mk(1'b1, 1'b1, 1'b1, 1'b1, 16'h0134, 32'h1234_5678));
        t0 = last_t0;
        err_pulse(2, mk(1'b1, 1'b0, 1'b1, 1'b0, 16'h0150, 32'h0000_0040));
        repeat (20) @(posedge clk_sys);
        check("merged exceptions", 32'h1, 32'(exc_cnt));
        check("broadcast pulses", 32'h1, 32'(sig_cnt));
        check("exception latency", 32'(AGG_CYC), 32'(exc_at - t0));
        check("vector", {24'h0, EXC_VECTOR}, {24'h0, vec_seen});
        rd_check(bank_a(0, B_STAT), 32'hB200_0134, RESP_OKAY, "fatal status");
        rd_check(bank_a(2, B_STAT), 32'hB000_0150, RESP_OKAY, "recoverable status");
        rd_check(bank_a(0, B_ADDR), 32'h1234_5678, RESP_OKAY, "fatal address");
        rd_check(A_GSTAT, 32'h0000_0006, RESP_OKAY, "fatal pointers");
        axi_write(A_FCTL, 32'h0000_0001, RESP_OKAY, "enable hold");
        $display("test aggregation done");

        // Handler clears in-progress and banks before the next event
        axi_write(A_GSTAT, 32'h0000_0000, RESP_OKAY, "handler clear");
        rd_check(A_GSTAT, 32'h0000_0000, RESP_OKAY, "in-progress cleared");
        for (int b = 0; b < NB; b++) axi_write(bank_a(b, B_STAT), 32'h0000_0000, RESP_OKAY, "bank clear");
        settle();
        err_pulse(3, mk(1'b1, 1'b0, 1'b1, 1'b1, 16'h0150, 32'hCAFE_0000));
        repeat (20) @(posedge clk_sys);
        check("single exception", 32'h1, 32'(exc_cnt));
        rd_check(A_GSTAT, 32'h0000_0007, RESP_OKAY, "pointers and in-progress");
        rd_check(A_LTYPE, 32'h0000_0150, RESP_OKAY, "legacy type");
        rd_check(A_LADDR, 32'hCAFE_0000, RESP_OKAY, "legacy address");
        axi_write(A_FCTL, 32'h0000_0000, RESP_OKAY, "disable");
        rd_check(A_LTYPE, 32'h0000_0000, RESP_OKAY, "legacy type disabled");
        rd_check(A_LADDR, 32'h0000_0000, RESP_OKAY, "legacy address disabled");
        settle();
        err_pulse(1, mk(1'b1, 1'b1, 1'b0, 1'b0, 16'h0021, 32'h0000_0000));
        repeat (20) @(posedge clk_sys);
        check("disabled no exception", 32'h0, 32'(exc_cnt));
        check("disabled no shutdown", 32'h0, {31'h0, shut});
        rd_check(bank_a(1, B_STAT), 32'hB200_0021, RESP_OKAY, "disabled still logged");
        $display("test enable done");

        // In-progress is still set, so a new exception is recursion
        axi_write(A_FCTL, 32'h0000_0001, RESP_OKAY, "re-enable");
        settle();
        err_pulse(0, mk(1'b1, 1'b0, 1'b0, 1'b0, 16'h0022, 32'h0000_0000));
        repeat (20) @(posedge clk_sys);
        check("recursion shutdown", 32'h1, {31'h0, shut});
        check("recursion no exception", 32'h0, 32'(exc_cnt));
        $display("test recursion done");
        print_verdict();
    end

    // Bounds the whole run at 20000 cycles, well above its expected length
    initial begin
        repeat (20000) @(posedge clk_sys);
        timed_out("run length");
    end
endmodule
